// ==== hdl/pcm_divider.sv ====
/*
  one-cycle enable pulse divider.
  assumes a single synchronous active-low reset domain.
*/
`timescale 1ns/100ps
module pcm_divider
  import pcm_pkg::*;
#(
  parameter int DIVIDE = 8
)
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic tick_in,
  output logic      tick_out
);
  localparam int CW = $clog2(DIVIDE + 1);
  logic [CW-1:0] count_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_q  <= '0;
      tick_out <= 1'b0;
    end
    else
    begin
      tick_out <= 1'b0;
      if (tick_in)
      begin
        if (count_q == CW'(DIVIDE - 1))
        begin
          count_q  <= '0;
          tick_out <= 1'b1;
        end
        else
        begin
          count_q <= count_q + 1'b1;
        end
      end
    end
  end
endmodule // pcm_divider

// ==== hdl/pcm_pkg.sv ====
/*
  constants of the power and clock manager register bank: offsets, fields, resets, timing.
  assumes a 32-bit axi4-lite register bus and a single 20 MHz clock.
*/
package pcm_pkg;
  localparam logic [7:0]  PCM_CORE_ON_OFS     = 8'h00;
  localparam logic [7:0]  PCM_CORE_OFF_OFS    = 8'h04;
  localparam logic [7:0]  PCM_CORE_STATE_OFS  = 8'h08;
  localparam logic [7:0]  PCM_UNIT_ON_OFS     = 8'h10;
  localparam logic [7:0]  PCM_UNIT_OFF_OFS    = 8'h14;
  localparam logic [7:0]  PCM_UNIT_STATE_OFS  = 8'h18;
  localparam logic [7:0]  PCM_GEN_SETUP_OFS   = 8'h20;
  localparam logic [7:0]  PCM_SUPPLY_CMD_OFS  = 8'h28;
  localparam logic [7:0]  PCM_SUPPLY_SET_OFS  = 8'h2C;
  localparam logic [7:0]  PCM_GEN_STATE_OFS   = 8'h30;
  localparam logic [7:0]  PCM_IRQ_UNMASK_OFS  = 8'h34;
  localparam logic [7:0]  PCM_IRQ_SUPP_OFS    = 8'h38;
  localparam logic [7:0]  PCM_IRQ_MASK_OFS    = 8'h3C;

  localparam logic [31:0] PCM_CORE_RESET      = 32'h0000_0001;
  localparam logic [31:0] PCM_UNIT_RESET      = 32'h0000_0000;
  localparam logic [31:0] PCM_GEN_RESET       = 32'h0000_0000;
  localparam logic [31:0] PCM_SUPPLY_RESET    = 32'h0000_0001;
  localparam logic [31:0] PCM_UNIT_VALID_MASK = 32'h0007_EFFC;
  localparam logic [31:0] PCM_SUPPLY_MASK     = 32'h0000_00FF;

  localparam int PCM_BYP_BIT   = 0;
  localparam int PCM_OSCEN_BIT = 1;
  localparam int PCM_PINOFF_BIT = 2;
  localparam int PCM_DIV_LSB   = 4;
  localparam int PCM_MUL_LSB   = 8;
  localparam int PCM_SRC_LSB   = 14;
  localparam int PCM_OSCNT_LSB = 16;
  localparam int PCM_PLLCNT_LSB = 24;
  localparam int PCM_STABLE_BIT = 0;
  localparam int PCM_LOCK_BIT  = 1;

  localparam logic [1:0] PCM_SRC_SLOW = 2'h0;
  localparam logic [1:0] PCM_SRC_OSC  = 2'h1;
  localparam logic [1:0] PCM_SRC_PLL  = 2'h2;
  localparam logic [2:0] PCM_DIV_RESERVED = 3'h7;

  localparam int PCM_CLK_HZ     = 20_000_000;
  localparam int PCM_SLOW_HZ    = 32_768;
  localparam int PCM_OSC_PRESC  = 8;
  localparam int PCM_SLOW_TICKS = PCM_CLK_HZ / PCM_SLOW_HZ;

  localparam logic [1:0] PCM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PCM_RESP_SLVERR = 2'h2;
endpackage

// ==== hdl/pcm_regs.sv ====
/*
  register bank of the power and clock manager on axi4-lite: core and unit clock gates,
  clock generator setup, start-up counters, status.
  assumes synchronous inputs on aclk at 20 MHz and a master keeping one write and one read.
*/
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps
module pcm_regs
  import pcm_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             core_clock_en,
  output logic [31:0]      unit_clock_en,
  output logic             osc_bypass,
  output logic             osc_enable,
  output logic             master_clock_pin_off,
  output logic [2:0]       divider_select,
  output logic [5:0]       pll_multiplier,
  output logic [1:0]       source_select,
  output logic             osc_stable_flag,
  output logic             pll_lock_flag
);
  logic        aw_held_q;
  logic [7:0]  aw_addr_q;
  logic        w_held_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_fire;
  logic [31:0] wr_val;
  logic [31:0] setup_q;
  logic [31:0] setup_d;
  logic        setup_ok;
  logic [31:0] supply_q;
  logic [7:0]  osc_cnt_q;
  logic [7:0]  pll_cnt_q;
  logic        slow_tick_q;
  logic [15:0] slow_cnt_q;
  logic        osc_tick;
  logic [31:0] rd_val;
  logic        rd_known;

  // reserved setup bits 3, 7, 30 and 31 always stored as zero
  localparam logic [31:0] SETUP_WMASK = 32'h3FFF_FF77;

  // slow clock tick from the main clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      slow_cnt_q  <= '0;
      slow_tick_q <= 1'b0;
    end
    else if (slow_cnt_q == 16'(PCM_SLOW_TICKS - 1))
    begin
      slow_cnt_q  <= '0;
      slow_tick_q <= 1'b1;
    end
    else
    begin
      slow_cnt_q  <= slow_cnt_q + 16'h0001;
      slow_tick_q <= 1'b0;
    end
  end

  pcm_divider #(
    .DIVIDE (PCM_OSC_PRESC)
  ) u_osc_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .tick_in  (slow_tick_q),
    .tick_out (osc_tick)
  );

  // write address and data captured in either order
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q     <= 1'b0;
      aw_addr_q     <= '0;
      s_axi_awready <= 1'b1;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_q     <= 1'b1;
      aw_addr_q     <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    else if (wr_fire)
    begin
      aw_held_q <= 1'b0;
    end
    else if (!aw_held_q && !s_axi_bvalid)
    begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_q     <= 1'b0;
      w_data_q     <= '0;
      w_strb_q     <= '0;
      s_axi_wready <= 1'b1;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_q     <= 1'b1;
      w_data_q     <= s_axi_wdata;
      w_strb_q     <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    else if (wr_fire)
    begin
      w_held_q <= 1'b0;
    end
    else if (!w_held_q && !s_axi_bvalid)
    begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= PCM_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr_q[7:6] == 2'b00) ? PCM_RESP_OKAY : PCM_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // byte lanes merged over the stored setup word
  always_comb
  begin
    wr_val = setup_q;
    for (int i = 0; i < 4; i++)
    begin
      if (w_strb_q[i])
      begin
        wr_val[i*8 +: 8] = w_data_q[i*8 +: 8];
      end
    end
  end

  // safety screen on a new generator setup
  always_comb
  begin
    logic [1:0] nsrc;
    logic [1:0] osrc;
    logic       nosc;
    logic [5:0] nmul;
    nsrc = wr_val[PCM_SRC_LSB +: 2];
    osrc = setup_q[PCM_SRC_LSB +: 2];
    nosc = wr_val[PCM_OSCEN_BIT];
    nmul = wr_val[PCM_MUL_LSB +: 6];
    setup_d  = wr_val;
    setup_ok = 1'b1;
    if (nsrc != PCM_SRC_SLOW && !(osc_stable_flag && nosc))
    begin
      setup_ok = 1'b0;
    end
    if ((nsrc == PCM_SRC_PLL || osrc == PCM_SRC_PLL) && nmul == 6'h00)
    begin
      setup_ok = 1'b0;
    end
    if ((osrc != PCM_SRC_SLOW) && !nosc)
    begin
      setup_ok = 1'b0;
    end
  end

  // generator setup register, reset to zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      setup_q <= PCM_GEN_RESET;
    end
    else if (wr_fire && aw_addr_q == PCM_GEN_SETUP_OFS && setup_ok)
    begin
      setup_q <= setup_d & SETUP_WMASK;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      supply_q <= PCM_SUPPLY_RESET;
    end
    else if (wr_fire && aw_addr_q == PCM_SUPPLY_SET_OFS)
    begin
      supply_q <= w_data_q & PCM_SUPPLY_MASK;
    end
  end

  // core and unit clock gates
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_clock_en <= PCM_CORE_RESET[0];
      unit_clock_en <= PCM_UNIT_RESET;
    end
    else if (wr_fire)
    begin
      if (aw_addr_q == PCM_CORE_ON_OFS && w_data_q[0])
      begin
        core_clock_en <= 1'b1;
      end
      if (aw_addr_q == PCM_CORE_OFF_OFS && w_data_q[0])
      begin
        core_clock_en <= 1'b0;
      end
      if (aw_addr_q == PCM_UNIT_ON_OFS)
      begin
        unit_clock_en <= unit_clock_en | (w_data_q & PCM_UNIT_VALID_MASK);
      end
      if (aw_addr_q == PCM_UNIT_OFF_OFS)
      begin
        unit_clock_en <= unit_clock_en & ~(w_data_q & PCM_UNIT_VALID_MASK);
      end
    end
  end

  // oscillator start-up and pll lock down-counters
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc_cnt_q       <= '0;
      osc_stable_flag <= 1'b0;
    end
    else if (wr_fire && aw_addr_q == PCM_GEN_SETUP_OFS && setup_ok && !setup_q[PCM_OSCEN_BIT]
             && setup_d[PCM_OSCEN_BIT] && setup_d[PCM_OSCNT_LSB +: 8] != 8'h00)
    begin
      osc_cnt_q       <= setup_d[PCM_OSCNT_LSB +: 8];
      osc_stable_flag <= 1'b0;
    end
    else if (!setup_q[PCM_OSCEN_BIT])
    begin
      osc_cnt_q       <= '0;
      osc_stable_flag <= 1'b0;
    end
    else if (osc_cnt_q == 8'h00)
    begin
      osc_stable_flag <= 1'b1;
    end
    else if (osc_tick)
    begin
      osc_cnt_q <= osc_cnt_q - 8'h01;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pll_cnt_q     <= '0;
      pll_lock_flag <= 1'b0;
    end
    else if (wr_fire && aw_addr_q == PCM_GEN_SETUP_OFS && setup_ok
             && setup_d[PCM_MUL_LSB +: 6] != setup_q[PCM_MUL_LSB +: 6])
    begin
      pll_lock_flag <= 1'b0;
      if (setup_d[PCM_MUL_LSB +: 6] != 6'h00 && setup_d[PCM_PLLCNT_LSB +: 6] != 6'h00)
      begin
        pll_cnt_q <= {2'b00, setup_d[PCM_PLLCNT_LSB +: 6]};
      end
    end
    else if (!osc_stable_flag || setup_q[PCM_MUL_LSB +: 6] == 6'h00)
    begin
      pll_lock_flag <= 1'b0;
    end
    else if (pll_cnt_q == 8'h00)
    begin
      pll_lock_flag <= 1'b1;
    end
    else if (slow_tick_q)
    begin
      pll_cnt_q <= pll_cnt_q - 8'h01;
    end
  end

  // generator controls out of the setup word
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      osc_bypass           <= 1'b0;
      osc_enable           <= 1'b0;
      master_clock_pin_off <= 1'b0;
      divider_select       <= '0;
      pll_multiplier       <= '0;
      source_select        <= PCM_SRC_SLOW;
    end
    else
    begin
      osc_bypass           <= setup_q[PCM_BYP_BIT];
      osc_enable           <= setup_q[PCM_OSCEN_BIT];
      master_clock_pin_off <= setup_q[PCM_PINOFF_BIT];
      divider_select       <= (setup_q[PCM_DIV_LSB +: 3] == PCM_DIV_RESERVED) ? 3'h0
                              : setup_q[PCM_DIV_LSB +: 3];
      pll_multiplier       <= setup_q[PCM_MUL_LSB +: 6];
      source_select        <= (setup_q[PCM_SRC_LSB +: 2] == 2'h3) ? PCM_SRC_SLOW
                              : setup_q[PCM_SRC_LSB +: 2];
    end
  end

  // read decode
  always_comb
  begin
    rd_val   = '0;
    rd_known = 1'b1;
    unique case (s_axi_araddr)
      PCM_CORE_STATE_OFS: rd_val = {31'h0, core_clock_en};
      PCM_UNIT_STATE_OFS: rd_val = unit_clock_en;
      PCM_GEN_SETUP_OFS:  rd_val = setup_q;
      PCM_SUPPLY_SET_OFS: rd_val = supply_q;
      PCM_GEN_STATE_OFS:  rd_val = {30'h0, pll_lock_flag, osc_stable_flag};
      default:            rd_known = (s_axi_araddr[7:6] == 2'b00);
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= PCM_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_known ? PCM_RESP_OKAY : PCM_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // pcm_regs

// ==== verif/pcm_regs_checker.sv ====
/*
  concurrent checks on the pcm_regs ports: clock gate writes and status reads.
  assumes binding to pcm_regs, one clock domain, synchronous active-low reset.
*/
`timescale 1ns/100ps
module pcm_regs_checker
  import pcm_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        core_clock_en,
  input wire logic [31:0] unit_clock_en,
  input wire logic [2:0]  divider_select,
  input wire logic        osc_stable_flag,
  input wire logic        pll_lock_flag
);
  logic [7:0]  wa_q;
  logic [31:0] wd_q;
  logic [7:0]  ra_q;

  // last taken addresses and data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wa_q <= 8'hFF;
      wd_q <= 32'h0000_0000;
      ra_q <= 8'hFF;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        wa_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
        wd_q <= s_axi_wdata;
      if (s_axi_arvalid && s_axi_arready)
        ra_q <= s_axi_araddr;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_core_on_write: assert property (
    $rose(s_axi_bvalid) && wa_q == 8'h00 && wd_q[0] |-> core_clock_en)
    else $error("core clock not started");
  a_core_off_write: assert property (
    $rose(s_axi_bvalid) && wa_q == 8'h04 && wd_q[0] |-> !core_clock_en)
    else $error("core clock not stopped");
  a_unit_on_bits: assert property (
    $rose(s_axi_bvalid) && wa_q == 8'h10
    |-> (unit_clock_en & wd_q & PCM_UNIT_VALID_MASK) == (wd_q & PCM_UNIT_VALID_MASK))
    else $error("unit clocks not started");
  a_unit_off_bits: assert property (
    $rose(s_axi_bvalid) && wa_q == 8'h14 |-> (unit_clock_en & wd_q) == 32'h0)
    else $error("unit clocks not stopped");
  a_core_state_read: assert property (
    $rose(s_axi_rvalid) && ra_q == 8'h08 |-> s_axi_rdata == {31'h0, $past(core_clock_en)})
    else $error("core state read wrong");
  a_unit_state_read: assert property (
    $rose(s_axi_rvalid) && ra_q == 8'h18 |-> s_axi_rdata == $past(unit_clock_en))
    else $error("unit state read wrong");
  a_cmd_reads_zero: assert property (
    $rose(s_axi_rvalid) && ra_q inside {8'h00, 8'h04, 8'h10, 8'h14} |-> s_axi_rdata == 32'h0)
    else $error("command offset read nonzero");
  a_divider_valid: assert property (
    divider_select != PCM_DIV_RESERVED)
    else $error("reserved divider shown");
  a_lock_needs_stable: assert property (
    $rose(pll_lock_flag) |-> $past(osc_stable_flag))
    else $error("lock without stable oscillator");

  c_core_off: cover property ($fell(core_clock_en));
  c_unit_on: cover property ($rose(unit_clock_en[2]));
  c_state_read: cover property ($rose(s_axi_rvalid) && ra_q == 8'h18);
endmodule // pcm_regs_checker

// ==== verif/power_clock_manager_regs_test.sv ====
/*
  self-checking bench for pcm_regs over axi4-lite.
  assumes pcm_pkg and pcm_regs_checker are compiled first.
*/
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin miscompares++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
module power_clock_manager_regs_test;
  import pcm_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, source_select;
  logic        core_clock_en, osc_bypass, osc_enable, master_clock_pin_off;
  logic        osc_stable_flag, pll_lock_flag;
  logic [31:0] unit_clock_en;
  logic [2:0]  divider_select;
  logic [5:0]  pll_multiplier;
  int          miscompares = 0;
  int          total_checks = 0;
  localparam logic [1:0] OK = PCM_RESP_OKAY;

  pcm_regs u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .core_clock_en(core_clock_en), .unit_clock_en(unit_clock_en),
    .osc_bypass(osc_bypass), .osc_enable(osc_enable),
    .master_clock_pin_off(master_clock_pin_off), .divider_select(divider_select),
    .pll_multiplier(pll_multiplier), .source_select(source_select),
    .osc_stable_flag(osc_stable_flag), .pll_lock_flag(pll_lock_flag));

  always #25 aclk = ~aclk;

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready)
      begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready)
      begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    `CHK("bresp", er, s_axi_bresp)
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er = OK);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    `CHK("rdata", ex, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
    s_axi_rready <= 1'b0;
  endtask

  task automatic wait_flag(input int lim, input bit lock);
    int n;
    n = 0;
    while ((lock ? pll_lock_flag : osc_stable_flag) !== 1'b1 && n < lim)
    begin
      @(posedge aclk);
      n++;
    end
  endtask

  task automatic t_reset;
    rd(PCM_CORE_STATE_OFS, PCM_CORE_RESET);
    rd(PCM_UNIT_STATE_OFS, 32'h0);
    rd(PCM_GEN_SETUP_OFS, 32'h0);
    rd(PCM_CORE_ON_OFS, 32'h0);
    rd(8'h0C, 32'h0);
    wr(8'h40, 32'hFFFF_FFFF, PCM_RESP_SLVERR);
    rd(8'h40, 32'h0, PCM_RESP_SLVERR);
    rd(PCM_UNIT_STATE_OFS, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_core;
    wr(PCM_CORE_OFF_OFS, 32'hFFFF_FFFE, OK);
    rd(PCM_CORE_STATE_OFS, 32'h1);
    wr(PCM_CORE_OFF_OFS, 32'h1, OK);
    rd(PCM_CORE_STATE_OFS, 32'h0);
    `CHK("core_en", 1'b0, core_clock_en)
    wr(PCM_CORE_ON_OFS, 32'hFFFF_FFFE, OK);
    rd(PCM_CORE_STATE_OFS, 32'h0);
    wr(PCM_CORE_ON_OFS, 32'h1, OK);
    rd(PCM_CORE_STATE_OFS, 32'h1);
    $display("test core done");
  endtask

  task automatic t_unit;
    wr(PCM_UNIT_ON_OFS, 32'hFFFF_FFFF, OK);
    rd(PCM_UNIT_STATE_OFS, PCM_UNIT_VALID_MASK);
    wr(PCM_UNIT_OFF_OFS, 32'h0004_0804, OK);
    rd(PCM_UNIT_STATE_OFS, PCM_UNIT_VALID_MASK & ~32'h0004_0804);
    wr(PCM_UNIT_ON_OFS, 32'h0000_0004, OK);
    rd(PCM_UNIT_STATE_OFS, PCM_UNIT_VALID_MASK & ~32'h0004_0800);
    wr(PCM_UNIT_OFF_OFS, 32'hFFFF_FFFF, OK);
    rd(PCM_UNIT_STATE_OFS, 32'h0);
    `CHK("unit_en", 32'h0, unit_clock_en)
    $display("test unit done");
  endtask

  task automatic t_setup;
    wr(PCM_GEN_SETUP_OFS, 32'h0000_0065, OK); // bypass with oscillator off
    rd(PCM_GEN_SETUP_OFS, 32'h0000_0065);
    `CHK("bypass", 1'b1, osc_bypass)
    `CHK("pin_off", 1'b1, master_clock_pin_off)
    `CHK("divider", 3'h6, divider_select)
    wr(PCM_GEN_SETUP_OFS, 32'h0000_0070, OK);
    wr(PCM_GEN_SETUP_OFS, 32'h0000_4070, OK);
    rd(PCM_GEN_SETUP_OFS, 32'h0000_0070);
    `CHK("div_rsv", 3'h0, divider_select)
    wr(PCM_GEN_SETUP_OFS, 32'h0, OK);
    $display("test setup done");
  endtask

  task automatic t_osc;
    wr(PCM_GEN_SETUP_OFS, 32'h0201_0002, OK);
    rd(PCM_GEN_STATE_OFS, 32'h0);
    `CHK("osc_en", 1'b1, osc_enable)
    wait_flag(10000, 1'b0);
    rd(PCM_GEN_STATE_OFS, 32'h1);
    `CHK("stable", 1'b1, osc_stable_flag)
    wr(PCM_GEN_SETUP_OFS, 32'h0201_4302, OK); // lock count of two
    @(negedge aclk);
    `CHK("mul", 6'h3, pll_multiplier)
    wait_flag(3000, 1'b1);
    rd(PCM_GEN_STATE_OFS, 32'h3);
    `CHK("lock", 1'b1, pll_lock_flag)
    wr(PCM_GEN_SETUP_OFS, 32'h0201_8302, OK);
    rd(PCM_GEN_SETUP_OFS, 32'h0201_8302);
    `CHK("src", PCM_SRC_PLL, source_select)
    wr(PCM_GEN_SETUP_OFS, 32'h0201_8002, OK);
    rd(PCM_GEN_SETUP_OFS, 32'h0201_8302);
    wr(PCM_GEN_SETUP_OFS, 32'h0201_4302, OK);
    wr(PCM_GEN_SETUP_OFS, 32'h0201_4300, OK);
    rd(PCM_GEN_SETUP_OFS, 32'h0201_4302);
    wr(PCM_GEN_SETUP_OFS, 32'h0201_0302, OK);
    wr(PCM_GEN_SETUP_OFS, 32'h0, OK);
    rd(PCM_GEN_STATE_OFS, 32'h0);
    `CHK("lock_off", 1'b0, pll_lock_flag)
    $display("test osc done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_core;
    t_unit;
    t_setup;
    t_osc;
    tally_and_finish;
  end

  initial
  begin
    repeat (40000) @(posedge aclk);
    miscompares++;
    tally_and_finish;
  end
endmodule // power_clock_manager_regs_test

bind pcm_regs pcm_regs_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .core_clock_en(core_clock_en), .unit_clock_en(unit_clock_en),
  .divider_select(divider_select), .osc_stable_flag(osc_stable_flag),
  .pll_lock_flag(pll_lock_flag));
